// ### design/scs_supervisor.sv
// Switchgear supervisor: position decoding, travel supervision, command gating, trip manager.
// Assumes all inputs synchronous to clock; relay routing done here from the relay assign masks.
`timescale 1ns/1ps
module scs_supervisor
  import scs_pkg::*;
#(
  parameter int unsigned MOVE_CLOSE_CYCLES = MOVE_CLOSE_CYC,
  parameter int unsigned MOVE_OPEN_CYCLES  = MOVE_OPEN_CYC,
  parameter int unsigned TRIP_HOLD_CYCLES  = TRIP_HOLD_CYC,
  parameter int unsigned SYNC_WAIT_CYCLES  = SYNC_WAIT_CYC,
  parameter int unsigned TRIP_SOURCES      = 4
) (
  input  wire logic                        clock,
  input  wire logic                        sys_rst,
  input  wire scs_contacts_type            contacts,
  input  wire scs_config_type              config_in,
  input  wire logic [INTERLOCK_COUNT-1:0]  close_interlock_input,
  input  wire logic [INTERLOCK_COUNT-1:0]  open_interlock_input,
  input  wire logic [TRIP_SOURCES-1:0]     trip_source_input,
  input  wire logic                        trip_acknowledge,
  input  wire logic                        external_close_request,
  input  wire logic                        external_open_request,
  input  wire logic                        panel_close_request,
  input  wire logic                        panel_open_request,
  input  wire logic                        sync_reached,
  input  wire logic [RELAY_COUNT-1:0]      relay_close_assign,
  input  wire logic [RELAY_COUNT-1:0]      relay_open_assign,
  output scs_status_type                   status,
  output logic                             close_command,
  output logic                             open_command,
  output logic                             trip_command,
  output logic [RELAY_COUNT-1:0]           relay_drive,
  output logic                             close_rejected,
  output logic                             open_rejected,
  output logic                             sync_abandoned
);
  typedef enum {
    SCS_IDLE,
    SCS_SYNC_WAIT,
    SCS_CLOSING,
    SCS_OPENING
  } scs_move_type;

  scs_move_type        move_state;
  logic                close_pulse;
  logic                open_pulse;
  logic                cfg_ok;
  logic                manual_allowed;
  logic                close_locked;
  logic                open_locked;
  logic                close_req;
  logic                open_req;
  logic                close_req_prev;
  logic                open_req_prev;
  logic                close_edge;
  logic                open_edge;
  logic [TRIP_SOURCES-1:0] trip_prev;
  logic                trip_rise;
  logic                trip_any;
  logic                trip_active;
  logic                hold_done;
  logic                hold_running;
  logic                travel_running;
  logic                travel_expired;
  logic                sync_expired;
  logic                start_close_travel;
  logic                start_open_travel;
  logic                stop_travel;
  logic [TIMER_WIDTH-1:0] travel_load;
  logic [1:0]          next_position;
  logic                second_contact;

  // Configuration check: first device must be able to break current
  assign cfg_ok = !(config_in.first_switching_device && !config_in.break_capability);
  assign manual_allowed = cfg_ok && config_in.controlled;

  assign close_locked = |close_interlock_input;
  assign open_locked  = |open_interlock_input;

  // Panel requests ignored for an invisible device; external ones still count
  assign close_req = external_close_request || (panel_close_request && !config_in.invisible);
  assign open_req  = external_open_request || (panel_open_request && !config_in.invisible);
  assign close_edge = close_req && !close_req_prev;
  assign open_edge  = open_req && !open_req_prev;

  assign trip_any  = |trip_source_input;
  assign trip_rise = |(trip_source_input & ~trip_prev);

  // Earthing combination uses the second contact as earth indication
  assign second_contact = contacts.open_contact;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      close_req_prev <= 1'b0;
      open_req_prev  <= 1'b0;
      trip_prev      <= '0;
    end else begin
      close_req_prev <= close_req;
      open_req_prev  <= open_req;
      trip_prev      <= trip_source_input;
    end
  end

  // Manual command acceptance and travel sequencing
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      move_state     <= SCS_IDLE;
      close_pulse    <= 1'b0;
      open_pulse     <= 1'b0;
      close_rejected <= 1'b0;
      open_rejected  <= 1'b0;
      sync_abandoned <= 1'b0;
    end else begin
      close_rejected <= 1'b0;
      open_rejected  <= 1'b0;
      sync_abandoned <= 1'b0;
      case (move_state)
        SCS_IDLE: begin
          if (trip_active) begin
            move_state <= SCS_OPENING;
          end else if (close_edge) begin
            if (!manual_allowed || close_locked) begin
              close_rejected <= 1'b1;
            end else if (config_in.sync_enable && config_in.break_capability) begin
              move_state <= SCS_SYNC_WAIT;
            end else begin
              move_state  <= SCS_CLOSING;
              close_pulse <= 1'b1;
            end
          end else if (open_edge) begin
            if (!manual_allowed || open_locked) begin
              open_rejected <= 1'b1;
            end else begin
              move_state <= SCS_OPENING;
              open_pulse <= 1'b1;
            end
          end
        end
        SCS_SYNC_WAIT: begin
          if (trip_active || close_locked) begin
            move_state     <= SCS_IDLE;
            sync_abandoned <= 1'b1;
          end else if (sync_reached) begin
            move_state  <= SCS_CLOSING;
            close_pulse <= 1'b1;
          end else if (config_in.gen_to_grid_sync_mode && sync_expired) begin
            move_state     <= SCS_IDLE;
            sync_abandoned <= 1'b1;
          end
        end
        SCS_CLOSING: begin
          if (trip_active) begin
            move_state  <= SCS_OPENING;
            close_pulse <= 1'b0;
          end else if (contacts.closed_contact && !second_contact || travel_expired) begin
            move_state  <= SCS_IDLE;
            close_pulse <= 1'b0;
          end
        end
        SCS_OPENING: begin
          if (!contacts.closed_contact && second_contact || travel_expired) begin
            move_state <= SCS_IDLE;
            open_pulse <= 1'b0;
          end else if (!open_pulse && !trip_active && !travel_running) begin
            move_state <= SCS_IDLE;
          end
        end
        default: begin
          move_state  <= SCS_IDLE;
          close_pulse <= 1'b0;
          open_pulse  <= 1'b0;
        end
      endcase
    end
  end

  assign start_close_travel = (move_state != SCS_CLOSING) && (close_pulse == 1'b0) &&
                              ((move_state == SCS_IDLE && close_edge && manual_allowed && !close_locked &&
                                !(config_in.sync_enable && config_in.break_capability) && !trip_active) ||
                               (move_state == SCS_SYNC_WAIT && sync_reached && !trip_active && !close_locked));
  assign start_open_travel  = (move_state != SCS_OPENING) &&
                              ((move_state == SCS_IDLE && (trip_active ||
                                (open_edge && !close_edge && manual_allowed && !open_locked))) ||
                               (move_state == SCS_CLOSING && trip_active));
  assign stop_travel = (move_state == SCS_CLOSING && contacts.closed_contact && !second_contact) ||
                       (move_state == SCS_OPENING && !contacts.closed_contact && second_contact);
  assign travel_load = start_close_travel ? TIMER_WIDTH'(MOVE_CLOSE_CYCLES) :
                                            TIMER_WIDTH'(MOVE_OPEN_CYCLES);

  // One timer serves both directions since only one travel is ever in flight
  scs_timer #(.WIDTH(TIMER_WIDTH)) u_travel (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .start      (start_close_travel || start_open_travel),
    .stop       (stop_travel),
    .load_value (travel_load),
    .running    (travel_running),
    .expired    (travel_expired)
  );

  scs_timer #(.WIDTH(TIMER_WIDTH)) u_sync (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .start      (move_state == SCS_IDLE && close_edge && manual_allowed && !close_locked &&
                 config_in.sync_enable && config_in.break_capability && !trip_active),
    .stop       (move_state != SCS_SYNC_WAIT && move_state != SCS_IDLE),
    .load_value (TIMER_WIDTH'(SYNC_WAIT_CYCLES)),
    .running    (),
    .expired    (sync_expired)
  );

  // Trip manager
  scs_timer #(.WIDTH(TIMER_WIDTH)) u_hold (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .start      (trip_rise && cfg_ok && config_in.break_capability),
    .stop       (1'b0),
    .load_value (TIMER_WIDTH'(TRIP_HOLD_CYCLES)),
    .running    (hold_running),
    .expired    ()
  );
  assign hold_done = !hold_running;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      trip_active <= 1'b0;
    end else if (!config_in.break_capability || !cfg_ok) begin
      trip_active <= 1'b0;
    end else if (trip_rise) begin
      trip_active <= 1'b1;
    end else if (trip_active && hold_done && !trip_any) begin
      // Source rise wins over acknowledge; acknowledge only acts after hold time
      if (!config_in.trip_latched || trip_acknowledge) begin
        trip_active <= 1'b0;
      end
    end
  end

  // Position decode
  always_comb begin
    next_position = POS_INDETERM;
    if (contacts.closed_contact && second_contact) begin
      next_position = POS_DISTURBED;
    end else if (contacts.closed_contact) begin
      next_position = POS_CLOSED;
    end else if (second_contact) begin
      next_position = POS_OPEN;
    end else if (travel_expired || !travel_running) begin
      next_position = POS_DISTURBED;
    end
  end

  // Outputs registered
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      status        <= '0;
      close_command <= 1'b0;
      open_command  <= 1'b0;
      trip_command  <= 1'b0;
      relay_drive   <= '0;
    end else begin
      status.position     <= next_position;
      status.earthed      <= config_in.earthing_combination && second_contact;
      status.ready        <= contacts.ready;
      status.removed      <= contacts.removed;
      status.config_error <= !cfg_ok;
      status.travel_fault <= travel_expired;
      close_command       <= close_pulse && manual_allowed;
      open_command        <= (open_pulse && manual_allowed) || trip_active;
      trip_command        <= trip_active;
      relay_drive         <= manual_allowed ?
                             ((relay_close_assign & {RELAY_COUNT{close_pulse}}) |
                              (relay_open_assign & {RELAY_COUNT{open_pulse || trip_active}})) : '0;
    end
  end
endmodule : scs_supervisor

// ### design/scs_pkg.sv
// Constants and carriers for the switchgear control supervisor.
// Assumes one 50 MHz clock and synchronous inputs from the protection logic.
package scs_pkg;
  localparam int unsigned CLOCK_HZ        = 50_000_000;
  localparam int unsigned INTERLOCK_COUNT = 3;
  localparam int unsigned RELAY_COUNT     = 7;
  localparam int unsigned TIMER_WIDTH     = 32;
  localparam logic [1:0]  POS_INDETERM    = 2'h0;
  localparam logic [1:0]  POS_OPEN        = 2'h1;
  localparam logic [1:0]  POS_CLOSED      = 2'h2;
  localparam logic [1:0]  POS_DISTURBED   = 2'h3;
  localparam int unsigned MOVE_CLOSE_MS   = 100;
  localparam int unsigned MOVE_OPEN_MS    = 100;
  localparam int unsigned TRIP_HOLD_MS    = 200;
  localparam int unsigned SYNC_WAIT_MS    = 1000;
  localparam int unsigned CYCLES_PER_MS   = CLOCK_HZ / 1000;
  localparam int unsigned MOVE_CLOSE_CYC  = MOVE_CLOSE_MS * CYCLES_PER_MS;
  localparam int unsigned MOVE_OPEN_CYC   = MOVE_OPEN_MS * CYCLES_PER_MS;
  localparam int unsigned TRIP_HOLD_CYC   = TRIP_HOLD_MS * CYCLES_PER_MS;
  localparam int unsigned SYNC_WAIT_CYC   = SYNC_WAIT_MS * CYCLES_PER_MS;

  typedef struct packed {
    logic closed_contact;
    logic open_contact;
    logic ready;
    logic removed;
  } scs_contacts_type;

  typedef struct packed {
    logic break_capability;
    logic controlled;
    logic invisible;
    logic earthing_combination;
    logic trip_latched;
    logic sync_enable;
    logic gen_to_grid_sync_mode;
    logic first_switching_device;
  } scs_config_type;

  typedef struct packed {
    logic [1:0] position;
    logic       earthed;
    logic       ready;
    logic       removed;
    logic       config_error;
    logic       travel_fault;
  } scs_status_type;
endpackage : scs_pkg

// ### design/scs_timer.sv
// Down-counting supervision timer: loads on start, flags expiry.
// Assumes start and stop are synchronous single-cycle or level requests.
`timescale 1ns/1ps
module scs_timer
  import scs_pkg::*;
#(
  parameter int unsigned WIDTH = TIMER_WIDTH
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             start,
  input  wire logic             stop,
  input  wire logic [WIDTH-1:0] load_value,
  output logic                  running,
  output logic                  expired
);
  logic [WIDTH-1:0] count;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count   <= '0;
      running <= 1'b0;
      expired <= 1'b0;
    end else if (start) begin
      count   <= (load_value == '0) ? WIDTH'(1) : load_value;
      running <= 1'b1;
      expired <= 1'b0;
    end else if (stop) begin
      running <= 1'b0;
      expired <= 1'b0;
    end else if (running) begin
      if (count <= WIDTH'(1)) begin
        running <= 1'b0;
        expired <= 1'b1;
      end else begin
        count <= count - WIDTH'(1);
      end
    end
  end
endmodule : scs_timer

// ### sim/scs_props.sv
// Assertions on the supervisor top ports.
// Assumes one clock, sync reset and configuration held steady by the bench.
`timescale 1ns/1ps
module scs_props
  import scs_pkg::*;
#(
  parameter int unsigned TRIP_HOLD_CYCLES = TRIP_HOLD_CYC,
  parameter int unsigned TRIP_SOURCES     = 4
) (
  input wire logic                       clock,
  input wire logic                       sys_rst,
  input wire scs_contacts_type           contacts,
  input wire scs_config_type             config_in,
  input wire logic [INTERLOCK_COUNT-1:0] close_interlock_input,
  input wire logic [TRIP_SOURCES-1:0]    trip_source_input,
  input wire logic                       trip_acknowledge,
  input wire logic                       external_close_request,
  input wire scs_status_type             status,
  input wire logic                       close_command,
  input wire logic                       open_command,
  input wire logic                       trip_command,
  input wire logic [RELAY_COUNT-1:0]     relay_drive,
  input wire logic                       close_rejected
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic [31:0] hold_cnt;
  // Counts cycles of trip high so the hold can be judged at the falling edge
  always_ff @(posedge clock) begin
    if (sys_rst || !trip_command) hold_cnt <= 32'h0;
    else hold_cnt <= hold_cnt + 32'h1;
  end
  sequence s_plain;
    !config_in.earthing_combination && !status.config_error;
  endsequence
  sequence s_idle_close;
    $rose(external_close_request) && config_in.controlled && !close_command && !open_command && !trip_command;
  endsequence
  a_pos_closed: assert property (
    (contacts.closed_contact && !contacts.open_contact)[*3] ##0 s_plain |-> status.position == POS_CLOSED)
    else $error("position not closed");
  a_pos_open: assert property (
    (!contacts.closed_contact && contacts.open_contact)[*3] ##0 s_plain |-> status.position == POS_OPEN)
    else $error("position not open");
  a_pos_both: assert property (
    (contacts.closed_contact && contacts.open_contact)[*3] ##0 s_plain |-> status.position == POS_DISTURBED)
    else $error("both contacts not disturbed");
  a_close_interlock: assert property (
    s_idle_close ##0 (|close_interlock_input) && !status.config_error |-> ##[1:3] close_rejected)
    else $error("interlocked close not refused");
  a_trip_start: assert property (
    $rose(|trip_source_input) && config_in.break_capability && !status.config_error |-> ##[1:3] trip_command)
    else $error("trip not issued");
  a_trip_hold: assert property (
    $fell(trip_command) |-> $past(hold_cnt) >= TRIP_HOLD_CYCLES - 2)
    else $error("trip released before hold time");
  a_trip_latch: assert property (
    (!trip_acknowledge)[*3] ##0 (trip_command && config_in.trip_latched) |=> trip_command)
    else $error("latched trip dropped without acknowledge");
  a_no_break_trip: assert property (
    (!config_in.break_capability)[*3] |-> !trip_command)
    else $error("trip without breaking capability");
  a_monitor_only: assert property (
    (!config_in.break_capability && !config_in.controlled)[*3] |-> !close_command && !open_command)
    else $error("command to monitored switchgear");
  a_uncontrolled: assert property (
    (!config_in.controlled)[*3] |-> !close_command && relay_drive == 7'h00)
    else $error("manual command while uncontrolled");
endmodule : scs_props
bind scs_supervisor scs_props #(.TRIP_HOLD_CYCLES(TRIP_HOLD_CYCLES), .TRIP_SOURCES(TRIP_SOURCES)) u_props (
  .clock(clock), .sys_rst(sys_rst), .contacts(contacts), .config_in(config_in),
  .close_interlock_input(close_interlock_input), .trip_source_input(trip_source_input),
  .trip_acknowledge(trip_acknowledge), .external_close_request(external_close_request), .status(status),
  .close_command(close_command), .open_command(open_command), .trip_command(trip_command),
  .relay_drive(relay_drive), .close_rejected(close_rejected));

// ### sim/scs_contacts_model.sv
// Behavioural auxiliary contacts of one breaker, moved by the command outputs.
// Assumes commands are levels; travel takes TRAVEL cycles, stuck releases both contacts.
`timescale 1ns/1ps
module scs_contacts_model
  import scs_pkg::*;
#(
  parameter int TRAVEL = 5
) (
  input  wire logic        clock,
  input  wire logic        close_command,
  input  wire logic        open_command,
  input  wire logic        stuck,
  input  wire logic        both_on,
  input  wire logic        ready_in,
  input  wire logic        removed_in,
  output scs_contacts_type contacts
);
  int   cnt        = 0;
  logic closed_pos = 1'b0;
  logic want;
  assign want = (close_command && !closed_pos) || (open_command && closed_pos);
  always @(posedge clock) begin
    if (!want || stuck) begin
      cnt <= 0;
    end else if (cnt == TRAVEL) begin
      closed_pos <= !closed_pos;
      cnt        <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // Contacts in travel are both released, not left at their last level
  assign contacts = {both_on || (!stuck && closed_pos && cnt == 0),
                     both_on || (!stuck && !closed_pos && cnt == 0), ready_in, removed_in};
endmodule : scs_contacts_model

// ### sim/switchgear_control_supervisor_test.sv
// Self-checking bench for the switchgear supervisor with a contact model.
// Assumes shortened timer parameters; inputs change at the falling edge.
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_total++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module switchgear_control_supervisor_test;
  import scs_pkg::*;
  localparam int MOVE = 30, HOLD = 20, SYNCW = 40;
  typedef struct packed {
    logic [7:0] cfg; logic [2:0] cil; logic [2:0] oil; logic [1:0] req; logic cmd; logic rej; logic [1:0] pos;
  } scs_row_type;
  logic             clock = 0, sys_rst = 1, ack = 0, sync_ok = 1, stuck = 0, both_on = 0, rdy = 0, rmv = 0;
  logic             ext_c = 0, ext_o = 0, pan_c = 0, pan_o = 0, close_command, open_command, trip_command;
  logic             close_rejected, open_rejected, sync_abandoned, seen_cmd, seen_rej, seen_flt;
  logic [2:0]       cil = 0, oil = 0;
  logic [3:0]       trip_src = 0;
  logic [6:0]       relay_drive, drv;
  scs_config_type   cfg = 8'hC1;
  scs_contacts_type contacts;
  scs_status_type   status;
  int               err_total = 0, n_compared = 0, cnt;
  // Row order matters: each row starts from the position the previous one left
  scs_row_type rows [11] = '{'{8'hC1,3'h0,3'h0,2'h0,1'b1,1'b0,2'h2}, '{8'hC1,3'h0,3'h0,2'h1,1'b1,1'b0,2'h1},
    '{8'hC1,3'h1,3'h0,2'h0,1'b0,1'b1,2'h1}, '{8'hC1,3'h2,3'h0,2'h0,1'b0,1'b1,2'h1},
    '{8'hC1,3'h4,3'h0,2'h0,1'b0,1'b1,2'h1}, '{8'hC1,3'h0,3'h0,2'h2,1'b1,1'b0,2'h2},
    '{8'hC1,3'h0,3'h0,2'h3,1'b1,1'b0,2'h1}, '{8'hC1,3'h0,3'h0,2'h2,1'b1,1'b0,2'h2},
    '{8'hC1,3'h0,3'h2,2'h1,1'b0,1'b1,2'h2}, '{8'hE1,3'h0,3'h0,2'h3,1'b0,1'b0,2'h2},
    '{8'h81,3'h0,3'h0,2'h1,1'b0,1'b1,2'h2}};
  initial begin
    forever #10 clock = !clock;
  end
  scs_supervisor #(.MOVE_CLOSE_CYCLES(MOVE), .MOVE_OPEN_CYCLES(MOVE), .TRIP_HOLD_CYCLES(HOLD),
    .SYNC_WAIT_CYCLES(SYNCW), .TRIP_SOURCES(4)) u_dut (
    .clock(clock), .sys_rst(sys_rst), .contacts(contacts), .config_in(cfg),
    .close_interlock_input(cil), .open_interlock_input(oil), .trip_source_input(trip_src),
    .trip_acknowledge(ack), .external_close_request(ext_c), .external_open_request(ext_o),
    .panel_close_request(pan_c), .panel_open_request(pan_o), .sync_reached(sync_ok),
    .relay_close_assign(7'h55), .relay_open_assign(7'h2A), .status(status), .close_command(close_command),
    .open_command(open_command), .trip_command(trip_command), .relay_drive(relay_drive),
    .close_rejected(close_rejected), .open_rejected(open_rejected), .sync_abandoned(sync_abandoned));
  scs_contacts_model #(.TRAVEL(5)) u_contacts (.clock(clock), .close_command(close_command),
    .open_command(open_command), .stuck(stuck), .both_on(both_on), .ready_in(rdy), .removed_in(rmv),
    .contacts(contacts));
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  // Drives one request as a short level, then watches commands, refusals and faults
  task automatic request(input logic [1:0] req, input int span);
    {pan_o, pan_c, ext_o, ext_c} = 4'h1 << req;
    {seen_cmd, seen_rej, seen_flt, drv} = '0;
    for (int k = 0; k < span; k++) begin
      @(negedge clock);
      if (k == 2) {pan_o, pan_c, ext_o, ext_c} = 4'h0;
      if ((close_command || open_command) && !seen_cmd) drv = relay_drive;
      seen_cmd = seen_cmd | close_command | open_command;
      seen_rej = seen_rej | close_rejected | open_rejected | sync_abandoned;
      seen_flt = seen_flt | status.travel_fault;
    end
    cnt = 0;
    while ((close_command || open_command || trip_command) && cnt < 100) begin
      @(negedge clock);
      cnt++;
    end
    repeat (3) @(negedge clock);
  endtask : request
  task automatic trip_pulse(input int span);
    trip_src = 4'h4;
    cnt = 0;
    for (int k = 0; k < span; k++) begin
      @(negedge clock);
      if (k == 2) trip_src = 4'h0;
      if (trip_command !== 1'b0) cnt++;
    end
  endtask : trip_pulse
  initial begin
    #(20 * 6000);
    err_total++;
    complete_run();
  end
  initial begin
    repeat (16) @(negedge clock);
    sys_rst = 0;
    repeat (3) @(negedge clock);
    `CHK(status.position, POS_OPEN)
    for (int i = 0; i < 11; i++) begin
      cfg = rows[i].cfg;
      cil = rows[i].cil;
      oil = rows[i].oil;
      repeat (3) @(negedge clock);
      request(rows[i].req, 12);
      `CHK(seen_cmd, rows[i].cmd)
      `CHK(seen_rej, rows[i].rej)
      `CHK(status.position, rows[i].pos)
      if (rows[i].cmd) `CHK(drv, rows[i].req[0] ? 7'h2A : 7'h55)
      $display("row %0d done", i);
    end
    {cfg, cil, oil} = {8'hC1, 6'h0};
    trip_pulse(100);
    `CHK(cnt >= HOLD && cnt <= HOLD + 4, 1'b1)
    `CHK(trip_command, 1'b0)
    `CHK(status.position, POS_OPEN)
    cfg = 8'hC9;
    trip_pulse(HOLD + 20);
    `CHK(trip_command, 1'b1)
    ack = 1;
    repeat (4) @(negedge clock);
    ack = 0;
    @(negedge clock);
    `CHK(trip_command, 1'b0)
    $display("trip tests done");
    cfg = 8'h00;
    repeat (3) @(negedge clock);
    trip_pulse(10);
    `CHK(cnt, 0)
    request(2'h0, 12);
    `CHK(seen_cmd, 1'b0)
    cfg = 8'h41;
    repeat (3) @(negedge clock);
    `CHK(status.config_error, 1'b1)
    cfg = 8'hD1;
    {rdy, rmv} = 2'h3;
    repeat (3) @(negedge clock);
    `CHK(status.config_error, 1'b0)
    `CHK(status.earthed, 1'b1)
    `CHK({status.ready, status.removed}, 2'h3)
    cfg = 8'hC1;
    both_on = 1;
    repeat (4) @(negedge clock);
    `CHK(status.position, POS_DISTURBED)
    both_on = 0;
    stuck = 1;
    request(2'h0, MOVE + 10);
    `CHK(seen_flt, 1'b1)
    `CHK(status.position, POS_DISTURBED)
    stuck = 0;
    cfg = 8'hC7;
    sync_ok = 0;
    repeat (3) @(negedge clock);
    request(2'h0, SYNCW + 10);
    `CHK(seen_rej, 1'b1)
    `CHK(status.position, POS_OPEN)
    // Without generator mode the close waits for synchronism with no limit
    cfg = 8'hC5;
    request(2'h0, SYNCW + 10);
    `CHK(seen_rej, 1'b0)
    sync_ok = 1;
    repeat (12) @(negedge clock);
    `CHK(status.position, POS_CLOSED)
    $display("awkward cases done");
    complete_run();
  end
endmodule : switchgear_control_supervisor_test
